// ==== ipwt_pkg.sv ====
package ipwt_pkg;

  // Host I/O port addresses
  localparam logic [15:0] IPWT_INDEX_PORT      = 16'h002E;
  localparam logic [15:0] IPWT_DATA_PORT       = 16'h002F;

  // Configuration keys written to the index port
  localparam logic [7:0]  IPWT_UNLOCK_KEY      = 8'h87;
  localparam logic [7:0]  IPWT_LOCK_KEY        = 8'hAA;

  // Register indices
  localparam logic [7:0]  IPWT_IDX_DEV_SELECT  = 8'h07;
  localparam logic [7:0]  IPWT_IDX_FUNC_ENABLE = 8'h30;
  localparam logic [7:0]  IPWT_IDX_UNIT_CFG    = 8'hF0;
  localparam logic [7:0]  IPWT_IDX_COUNT       = 8'hF1;
  localparam logic [7:0]  IPWT_IDX_CTRL_STAT   = 8'hF2;

  // Logical device number of the supervision timer
  localparam logic [7:0]  IPWT_SUPERVISION_TIMER_LDN = 8'h08;

  // Field positions
  localparam int          IPWT_ENABLE_BIT      = 0;
  localparam int          IPWT_UNIT_MIN_BIT    = 3;
  localparam int          IPWT_MOUSE_BIT       = 7;
  localparam int          IPWT_KBD_BIT         = 6;
  localparam int          IPWT_FORCE_BIT       = 5;
  localparam int          IPWT_STATUS_BIT      = 4;

  // Reset and read values
  localparam logic [7:0]  IPWT_DEV_SELECT_RST  = 8'h00;
  localparam logic [7:0]  IPWT_COUNT_RST       = 8'h00;
  localparam logic [7:0]  IPWT_RD_IDLE         = 8'hFF;
  localparam logic [7:0]  IPWT_RD_UNMAPPED     = 8'h00;

  // Timing
  localparam longint      IPWT_CLK_PERIOD_NS   = 100;
  localparam longint      IPWT_SECOND_NS       = 1000000000;
  localparam longint      IPWT_SECOND_CYCLES   = IPWT_SECOND_NS / IPWT_CLK_PERIOD_NS;
  localparam int          IPWT_SEC_PER_MIN     = 60;
  localparam int          IPWT_DIV_WIDTH       = 24;

  // Configuration access states
  typedef enum logic [1:0] {
    IPWT_LOCKED,
    IPWT_HALF_KEY,
    IPWT_OPEN
  } ipwt_access_type;

endpackage

// ==== ipwt_count_if.sv ====
`timescale 1ns/1ps
interface ipwt_count_if;
  logic       load;
  logic [7:0] loadValue;
  logic       run;
  logic       tick;
  logic [7:0] count;
  logic       expire;

  modport ctrl (output load, output loadValue, output run, output tick,
                input count, input expire);
  modport cnt  (input load, input loadValue, input run, input tick,
                output count, output expire);
endinterface

// ==== ipwt_tick_div.sv ====
`timescale 1ns/1ps
module ipwt_tick_div
  import ipwt_pkg::*;
#(
  parameter int unsigned DIV   = 10,
  parameter int unsigned WIDTH = 24
) (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic restart,
  input  wire logic tickIn,
  output logic      tickOut
);
  logic [WIDTH-1:0] phase_r;
  wire              wrap = tickIn && (phase_r == WIDTH'(DIV - 1));

  // Counts input ticks, pulses once every DIV of them
  always_ff @(posedge ref_clk) begin
    if (srst || restart) begin
      phase_r <= '0;
      tickOut <= 1'b0;
    end else begin
      tickOut <= wrap;
      if (wrap) begin
        phase_r <= '0;
      end else if (tickIn) begin
        phase_r <= phase_r + WIDTH'(1);
      end
    end
  end
endmodule

// ==== ipwt_countdown.sv ====
`timescale 1ns/1ps
module ipwt_countdown
  import ipwt_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic srst,
  ipwt_count_if.cnt cif
);
  wire lastUnit = cif.run && cif.tick && (cif.count == 8'h01);

  // Load wins; zero holds the counter stopped
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cif.count  <= IPWT_COUNT_RST;
      cif.expire <= 1'b0;
    end else begin
      cif.expire <= lastUnit && !cif.load;
      if (cif.load) begin
        cif.count <= cif.loadValue;
      end else if (cif.run && cif.tick && (cif.count != 8'h00)) begin
        cif.count <= cif.count - 8'h01;
      end
    end
  end
endmodule

// ==== ipwt_top.sv ====
// Summary of operation
// R1: Index port plus adjacent data port
// R2: Host writes index before data access
// R3: Two unlock key writes open configuration
// R4: Device number eight selects timer registers
// R5: Timer disabled until enable written one
// R6: Unit bit three: seconds or minutes
// R7: Zero count holds timer stopped
// R8: Nonzero count sets units until timeout
// R9: Expiry without reload raises timeout output
// R10: Count write restarts countdown as reload
// R11: Control bit seven enables mouse reload
// R12: Control bit six enables keyboard reload
// R13: Control bit five forces timeout, self-clears
// R14: Control bit four reads timeout status
// R15: Lock key write closes configuration
// R16: Timeout spans 1 to 255 units
// R17: Prescaled unit tick decrements, zero expires
`timescale 1ns/1ps
module ipwt_top
  import ipwt_pkg::*;
#(
  parameter longint SECOND_CYCLES = IPWT_SECOND_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [15:0] ioAddr,
  input  wire logic        ioWrStb,
  input  wire logic        ioRdStb,
  input  wire logic [7:0]  ioWrData,
  output logic      [7:0]  ioRdData,
  input  wire logic        kbdActivity,
  input  wire logic        mouseActivity,
  output logic             timeoutPulse,
  output logic             timeoutStatus
);

  // Access state and latched index
  ipwt_access_type accessState_r;
  ipwt_access_type accessState_nxt;
  logic [7:0]      index_r;

  // Register contents
  logic [7:0]      devSelect_r;
  logic            enable_r;
  logic            unitMinutes_r;
  logic [7:0]      timeoutCount_r;
  logic            mouseReload_r;
  logic            kbdReload_r;
  logic            status_r;
  logic            forcePending_r;

  // Count path carrier
  ipwt_count_if    cif ();

  // Tick chain
  logic            secTick;
  logic            minTick;

  // Port decode
  wire             indexHit   = (ioAddr == IPWT_INDEX_PORT);   // [R1]
  wire             dataHit    = (ioAddr == IPWT_DATA_PORT);    // [R1]
  wire             indexWr    = ioWrStb && indexHit;
  wire             dataWr     = ioWrStb && dataHit;
  wire             dataRd     = ioRdStb && dataHit;
  wire             indexRd    = ioRdStb && indexHit;
  wire             idleRd     = dataRd || indexRd;

  // Configuration currently open
  wire             isOpen     = (accessState_r == IPWT_OPEN);          // [R3]

  // Data port reaches the register picked by the last index write
  wire             openDataWr = dataWr && isOpen;              // [R2]
  wire             openDataRd = dataRd && isOpen;              // [R2]

  // Key values seen on the index port
  wire             unlockKeyWr = indexWr && (ioWrData == IPWT_UNLOCK_KEY); // [R3]
  wire             lockKeyWr   = indexWr && (ioWrData == IPWT_LOCK_KEY);   // [R15]
  wire             indexLoad   = indexWr && isOpen && !lockKeyWr;          // [R2]

  // Timer registers answer only while its logical device is selected
  wire             timerSel   = (devSelect_r == IPWT_SUPERVISION_TIMER_LDN); // [R4]

  // Register decode on the latched index
  wire             selDev     = (index_r == IPWT_IDX_DEV_SELECT);
  wire             selEnable  = timerSel && (index_r == IPWT_IDX_FUNC_ENABLE);
  wire             selUnit    = timerSel && (index_r == IPWT_IDX_UNIT_CFG);
  wire             selCount   = timerSel && (index_r == IPWT_IDX_COUNT);
  wire             selCtrl    = timerSel && (index_r == IPWT_IDX_CTRL_STAT);

  // Write strobes per register
  wire             wrDev      = openDataWr && selDev;
  wire             wrEnable   = openDataWr && selEnable;
  wire             wrUnit     = openDataWr && selUnit;
  wire             wrCount    = openDataWr && selCount;
  wire             wrCtrl     = openDataWr && selCtrl;

  // Fields of the byte written on the data port
  wire             wrEnableBit = ioWrData[IPWT_ENABLE_BIT];
  wire             wrUnitBit   = ioWrData[IPWT_UNIT_MIN_BIT];
  wire             wrMouseBit  = ioWrData[IPWT_MOUSE_BIT];
  wire             wrKbdBit    = ioWrData[IPWT_KBD_BIT];
  wire             wrForceBit  = ioWrData[IPWT_FORCE_BIT];

  // Reload sources
  wire             mouseKick  = mouseReload_r && mouseActivity;   // [R11]
  wire             kbdKick    = kbdReload_r && kbdActivity;       // [R12]
  wire             hwReload   = mouseKick || kbdKick;
  wire             anyReload  = wrCount || hwReload;

  // Value loaded into the counter: new write or programmed interval
  wire [7:0]       reloadVal  = wrCount ? ioWrData : timeoutCount_r; // [R10]

  // Force request taken from a control write with bit five set
  wire             forceWr    = wrCtrl && wrForceBit;               // [R13]

  // Countdown, expiry and force wait on the enable bit
  wire             timerLive  = enable_r;                            // [R5]

  // Timeout events: countdown expiry or forced
  wire             forceFire  = forcePending_r && timerLive;         // [R13]
  wire             expireFire = cif.expire && timerLive;             // [R9]
  wire             timeoutEvt = forceFire || expireFire;

  // Status clears on a fresh count write or when the timer is disabled
  wire             statusClr  = wrCount || (wrEnable && !wrEnableBit);

  // Status after this edge; a new event wins over a clear
  wire             statusNxt  = timeoutEvt || (status_r && !statusClr); // [R14]

  // Control register read image
  wire [7:0]       ctrlImage  = {mouseReload_r, kbdReload_r, 1'b0, status_r, 4'h0}; // [R14]

  // Read words of each register
  wire [7:0]       devWord    = devSelect_r;                      // [R4]
  wire [7:0]       enableWord = {7'h00, enable_r};                // [R5]
  wire [7:0]       unitWord   = {4'h0, unitMinutes_r, 3'h0};      // [R6]
  wire [7:0]       countWord  = timeoutCount_r;                   // [R8]

  // Read data selection
  wire [7:0]       rdImage;
  assign rdImage = selDev    ? devWord :
                   selEnable ? enableWord :
                   selUnit   ? unitWord :
                   selCount  ? countWord :
                   selCtrl   ? ctrlImage :
                               IPWT_RD_UNMAPPED;

  // Unlock and lock sequence on the index port
  always_comb begin
    accessState_nxt = accessState_r;
    case (accessState_r)
      IPWT_LOCKED: begin
        if (unlockKeyWr) begin
          accessState_nxt = IPWT_HALF_KEY;                        // [R3]
        end
      end
      IPWT_HALF_KEY: begin
        if (indexWr) begin
          if (unlockKeyWr) begin
            accessState_nxt = IPWT_OPEN;                          // [R3]
          end else begin
            accessState_nxt = IPWT_LOCKED;                        // [R3]
          end
        end
      end
      IPWT_OPEN: begin
        if (lockKeyWr) begin
          accessState_nxt = IPWT_LOCKED;                          // [R15]
        end
      end
      default: begin
        accessState_nxt = IPWT_LOCKED;
      end
    endcase
  end

  // Access state register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      accessState_r <= IPWT_LOCKED;
    end else begin
      accessState_r <= accessState_nxt;
    end
  end

  // Index latch while configuration is open
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      index_r <= 8'h00;
    end else if (indexLoad) begin
      index_r <= ioWrData;                                        // [R2]
    end
  end

  // Logical device select
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      devSelect_r <= IPWT_DEV_SELECT_RST;
    end else if (wrDev) begin
      devSelect_r <= ioWrData;                                    // [R4]
    end
  end

  // Function enable, off after reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      enable_r <= 1'b0;                                           // [R5]
    end else if (wrEnable) begin
      enable_r <= wrEnableBit;                                    // [R5]
    end
  end

  // Counting unit, seconds after reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      unitMinutes_r <= 1'b0;                                      // [R6]
    end else if (wrUnit) begin
      unitMinutes_r <= wrUnitBit;                                 // [R6]
    end
  end

  // Programmed interval, 1 to 255 units or zero for stopped
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      timeoutCount_r <= IPWT_COUNT_RST;                           // [R7]
    end else if (wrCount) begin
      timeoutCount_r <= ioWrData;                                 // [R16]
    end
  end

  // Mouse reload enable, off after reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mouseReload_r <= 1'b0;                                      // [R11]
    end else if (wrCtrl) begin
      mouseReload_r <= wrMouseBit;                                // [R11]
    end
  end

  // Keyboard reload enable, off after reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      kbdReload_r <= 1'b0;                                        // [R12]
    end else if (wrCtrl) begin
      kbdReload_r <= wrKbdBit;                                    // [R12]
    end
  end

  // Force request held one cycle, never stored as a readable bit
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      forcePending_r <= 1'b0;
    end else begin
      forcePending_r <= forceWr;                                  // [R13]
    end
  end

  // Sticky timeout status; a new event wins over a clear
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status_r <= 1'b0;
    end else if (timeoutEvt) begin
      status_r <= 1'b1;                                           // [R14]
    end else if (statusClr) begin
      status_r <= 1'b0;
    end
  end

  // Timeout pulse, one cycle per event
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      timeoutPulse <= 1'b0;
    end else begin
      timeoutPulse <= timeoutEvt;                                 // [R9]
    end
  end

  // Status pin, always equal to the readable status bit
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      timeoutStatus <= 1'b0;
    end else begin
      timeoutStatus <= statusNxt;                                 // [R14]
    end
  end

  // Registered read data on the data port
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ioRdData <= IPWT_RD_IDLE;
    end else if (openDataRd) begin
      ioRdData <= rdImage;                                        // [R1]
    end else if (idleRd) begin
      ioRdData <= IPWT_RD_IDLE;
    end
  end

  // Prescalers restart with every reload so a new count gets whole units
  wire             unitRestart = anyReload;                       // [R10]

  // One second tick from the device clock
  ipwt_tick_div #(
    .DIV   (int'(SECOND_CYCLES)),
    .WIDTH (IPWT_DIV_WIDTH)
  ) u_sec_div (
    .ref_clk (ref_clk),
    .srst    (srst),
    .restart (unitRestart),
    .tickIn  (1'b1),
    .tickOut (secTick)
  );

  // One minute tick from sixty seconds
  ipwt_tick_div #(
    .DIV   (IPWT_SEC_PER_MIN),
    .WIDTH (IPWT_DIV_WIDTH)
  ) u_min_div (
    .ref_clk (ref_clk),
    .srst    (srst),
    .restart (unitRestart),
    .tickIn  (secTick),
    .tickOut (minTick)
  );

  // Unit tick picked by the unit bit
  wire             unitTick   = unitMinutes_r ? minTick : secTick;  // [R6] [R17]

  // Countdown control
  assign cif.load      = anyReload;                               // [R10]
  assign cif.loadValue = reloadVal;
  assign cif.run       = timerLive;                               // [R5]
  assign cif.tick      = unitTick;                                // [R17]

  // Countdown of whole units to expiry
  ipwt_countdown u_countdown (
    .ref_clk (ref_clk),
    .srst    (srst),
    .cif     (cif.cnt)                                            // [R8]
  );

endmodule

// ==== ipwt_host_model.sv ====
`timescale 1ns/1ps
module ipwt_host_model
  import ipwt_pkg::*;
(
  input  wire logic        ref_clk,
  output logic      [15:0] ioAddr,
  output logic             ioWrStb,
  output logic             ioRdStb,
  output logic      [7:0]  ioWrData,
  input  wire logic [7:0]  ioRdData
);
  // Bus quiet at time zero
  initial begin
    ioAddr = 16'h0000;
    ioWrStb = 1'b0;
    ioRdStb = 1'b0;
    ioWrData = 8'h00;
  end

  // One I/O cycle, held up to the sampling edge
  task automatic busCyc(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    ioAddr = a;
    ioWrData = d;
    ioWrStb = wr;
    ioRdStb = !wr;
    @(posedge ref_clk);
    #1;
    ioWrStb = 1'b0;
    ioRdStb = 1'b0;
    ioWrData = ~d; // Released data shows no stale value
  endtask

  // Index first, then data
  task automatic regWr(input logic [7:0] idx, input logic [7:0] d);
    busCyc(1'b1, IPWT_INDEX_PORT, idx);
    busCyc(1'b1, IPWT_DATA_PORT, d);
  endtask

  // Index first, then data read
  task automatic regRd(input logic [7:0] idx, output logic [7:0] d);
    busCyc(1'b1, IPWT_INDEX_PORT, idx);
    busCyc(1'b0, IPWT_DATA_PORT, 8'h00);
    d = ioRdData;
  endtask

  // Double key write opens access
  task automatic unlock();
    busCyc(1'b1, IPWT_INDEX_PORT, IPWT_UNLOCK_KEY);
    busCyc(1'b1, IPWT_INDEX_PORT, IPWT_UNLOCK_KEY);
  endtask

  // Close access after programming
  task automatic lock();
    busCyc(1'b1, IPWT_INDEX_PORT, IPWT_LOCK_KEY);
  endtask
endmodule

// ==== ipwt_assertions.sv ====
`timescale 1ns/1ps
module ipwt_assertions
  import ipwt_pkg::*;
#(
  parameter longint SECOND_CYCLES = IPWT_SECOND_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [15:0] ioAddr,
  input  wire logic        ioWrStb,
  input  wire logic        ioRdStb,
  input  wire logic [7:0]  ioWrData,
  input  wire logic [7:0]  ioRdData,
  input  wire logic        kbdActivity,
  input  wire logic        mouseActivity,
  input  wire logic        timeoutPulse,
  input  wire logic        timeoutStatus
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [1:0] keySt_r;
  logic [7:0] idx_r;
  logic [7:0] dev_r;
  logic       en_r;
  // Port decode and shadow events
  wire wrIdx   = ioWrStb && ioAddr == IPWT_INDEX_PORT;
  wire wrDat   = ioWrStb && ioAddr == IPWT_DATA_PORT;
  wire rdIdx   = ioRdStb && ioAddr == IPWT_INDEX_PORT;
  wire rdDat   = ioRdStb && ioAddr == IPWT_DATA_PORT;
  wire openW   = keySt_r == 2'h2;
  wire tmrW    = openW && wrDat && dev_r == IPWT_SUPERVISION_TIMER_LDN;
  wire clrEv   = tmrW && (idx_r == IPWT_IDX_COUNT
                 || (idx_r == IPWT_IDX_FUNC_ENABLE && !ioWrData[0]));
  wire forceEv = tmrW && en_r && idx_r == IPWT_IDX_CTRL_STAT && ioWrData[IPWT_FORCE_BIT];
  // Shadow of key state, index, device and enable
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      keySt_r <= 2'h0;
      idx_r <= 8'h00;
      dev_r <= 8'h00;
      en_r <= 1'b0;
    end else if (wrIdx) begin
      if (ioWrData == IPWT_LOCK_KEY) keySt_r <= 2'h0;
      else if (openW) idx_r <= ioWrData;
      else keySt_r <= (ioWrData == IPWT_UNLOCK_KEY) ? keySt_r + 2'h1 : 2'h0;
    end else if (openW && wrDat) begin
      if (idx_r == IPWT_IDX_DEV_SELECT) dev_r <= ioWrData;
      if (tmrW && idx_r == IPWT_IDX_FUNC_ENABLE) en_r <= ioWrData[0];
    end
  end
  pulse_single_a: assert property (timeoutPulse |=> !timeoutPulse)
    else $error("timeout pulse longer than one cycle");
  status_with_pulse_a: assert property (timeoutPulse |-> timeoutStatus)
    else $error("status low during timeout pulse");
  status_cause_a: assert property ($rose(timeoutStatus) |-> timeoutPulse)
    else $error("status rose without a timeout");
  status_clear_a: assert property ($fell(timeoutStatus) |-> $past(clrEv))
    else $error("status cleared without a cause");
  clear_effect_a: assert property (clrEv |=> !timeoutStatus || timeoutPulse)
    else $error("status not cleared");
  force_pulse_a: assert property (forceEv |-> ##2 timeoutPulse)
    else $error("forced timeout missing");
  locked_read_a: assert property (rdDat && !openW |=> ioRdData == IPWT_RD_IDLE)
    else $error("locked read not idle");
  index_read_a: assert property (rdIdx |=> ioRdData == IPWT_RD_IDLE)
    else $error("index read not idle");
  read_hold_a: assert property (!(rdIdx || rdDat) |=> $stable(ioRdData))
    else $error("read data changed without read");
  reset_idle_a: assert property ($fell(srst) |-> ioRdData == IPWT_RD_IDLE && !timeoutStatus)
    else $error("outputs not idle after reset");
endmodule

bind ipwt_top ipwt_assertions #(.SECOND_CYCLES(SECOND_CYCLES)) ipwt_assertions_inst (
  .ref_clk(ref_clk), .srst(srst), .ioAddr(ioAddr), .ioWrStb(ioWrStb),
  .ioRdStb(ioRdStb), .ioWrData(ioWrData), .ioRdData(ioRdData),
  .kbdActivity(kbdActivity), .mouseActivity(mouseActivity),
  .timeoutPulse(timeoutPulse), .timeoutStatus(timeoutStatus));

// ==== ipwt_top_tb.sv ====
`timescale 1ns/1ps
module ipwt_top_tb
  import ipwt_pkg::*;
;
  localparam longint SC = 10;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        kbdActivity = 1'b0;
  logic        mouseActivity = 1'b0;
  logic [15:0] ioAddr;
  logic        ioWrStb;
  logic        ioRdStb;
  logic [7:0]  ioWrData;
  logic [7:0]  ioRdData;
  logic        timeoutPulse;
  logic        timeoutStatus;
  logic [7:0]  rdv;
  int          fails = 0;
  int          checks_done = 0;
  int          n;
  int          cnt[3] = '{1, 3, 255};
  logic [7:0]  ctl[3] = '{8'h40, 8'h80, 8'h40};
  // Clock at 10 MHz
  always #50 ref_clk = ~ref_clk;
  ipwt_top #(.SECOND_CYCLES(SC)) ipwt_top_inst (
    .ref_clk(ref_clk), .srst(srst), .ioAddr(ioAddr), .ioWrStb(ioWrStb),
    .ioRdStb(ioRdStb), .ioWrData(ioWrData), .ioRdData(ioRdData),
    .kbdActivity(kbdActivity), .mouseActivity(mouseActivity),
    .timeoutPulse(timeoutPulse), .timeoutStatus(timeoutStatus));
  ipwt_host_model ipwt_host_model_inst (
    .ref_clk(ref_clk), .ioAddr(ioAddr), .ioWrStb(ioWrStb), .ioRdStb(ioRdStb),
    .ioWrData(ioWrData), .ioRdData(ioRdData));
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Cycles up to the next timeout pulse, max+1 when none
  task automatic waitPulse(input int max, output int c);
    c = 0;
    while (c <= max) begin
      @(posedge ref_clk);
      #1;
      c++;
      if (timeoutPulse === 1'b1) break;
    end
  endtask
  // One cycle of input activity
  task automatic activity(input logic k, input logic m);
    @(posedge ref_clk);
    #1;
    kbdActivity = k;
    mouseActivity = m;
    @(posedge ref_clk);
    #1;
    kbdActivity = 1'b0;
    mouseActivity = 1'b0;
  endtask
  // Watchdog on the whole run
  initial begin
    #(100 * 20000);
    fails++;
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    #1 srst = 1'b0;
    ipwt_host_model_inst.busCyc(1'b0, IPWT_DATA_PORT, 8'h00);
    check(ioRdData, 8'hFF);
    ipwt_host_model_inst.busCyc(1'b0, IPWT_INDEX_PORT, 8'h00);
    check(ioRdData, 8'hFF);
    ipwt_host_model_inst.busCyc(1'b1, IPWT_INDEX_PORT, IPWT_UNLOCK_KEY);
    ipwt_host_model_inst.busCyc(1'b1, IPWT_INDEX_PORT, IPWT_IDX_DEV_SELECT);
    ipwt_host_model_inst.busCyc(1'b1, IPWT_INDEX_PORT, IPWT_UNLOCK_KEY);
    ipwt_host_model_inst.busCyc(1'b0, IPWT_DATA_PORT, 8'h00);
    check(ioRdData, 8'hFF);
    ipwt_host_model_inst.busCyc(1'b1, IPWT_INDEX_PORT, IPWT_UNLOCK_KEY);
    ipwt_host_model_inst.regRd(IPWT_IDX_DEV_SELECT, rdv);
    check(rdv, 8'h00);
    ipwt_host_model_inst.regWr(IPWT_IDX_FUNC_ENABLE, 8'h01);
    ipwt_host_model_inst.regWr(IPWT_IDX_DEV_SELECT, IPWT_SUPERVISION_TIMER_LDN);
    ipwt_host_model_inst.regRd(IPWT_IDX_DEV_SELECT, rdv);
    check(rdv, 8'h08);
    ipwt_host_model_inst.regRd(IPWT_IDX_FUNC_ENABLE, rdv);
    check(rdv, 8'h00);
    ipwt_host_model_inst.regRd(IPWT_IDX_UNIT_CFG, rdv);
    check(rdv, 8'h00);
    ipwt_host_model_inst.regRd(IPWT_IDX_CTRL_STAT, rdv);
    check(rdv, 8'h00);
    ipwt_host_model_inst.regRd(8'h55, rdv);
    check(rdv, IPWT_RD_UNMAPPED);
    ipwt_host_model_inst.regWr(IPWT_IDX_FUNC_ENABLE, 8'h01);
    waitPulse(60, n);
    check(n, 61);
    // Count table with both end values
    for (int i = 0; i < 3; i++) begin
      ipwt_host_model_inst.regWr(IPWT_IDX_COUNT, cnt[i][7:0]);
      check(timeoutStatus, 1'b0);
      waitPulse(cnt[i] * SC + 5, n);
      check(n >= cnt[i] * SC + 1 && n <= cnt[i] * SC + 3, 1'b1);
      check(timeoutStatus, 1'b1);
      ipwt_host_model_inst.regRd(IPWT_IDX_CTRL_STAT, rdv);
      check(rdv[IPWT_STATUS_BIT], 1'b1);
    end
    // Rewrite of the count restarts it
    ipwt_host_model_inst.regWr(IPWT_IDX_COUNT, 8'h02);
    waitPulse(15, n);
    check(n, 16);
    ipwt_host_model_inst.regWr(IPWT_IDX_COUNT, 8'h02);
    waitPulse(30, n);
    check(n >= 21 && n <= 23, 1'b1);
    // Keyboard, mouse, and mouse without its enable
    for (int i = 0; i < 3; i++) begin
      ipwt_host_model_inst.regWr(IPWT_IDX_CTRL_STAT, ctl[i]);
      ipwt_host_model_inst.regWr(IPWT_IDX_COUNT, 8'h02);
      waitPulse(10, n);
      activity(i == 0, i != 0);
      waitPulse(40, n);
      check(n >= ((i < 2) ? 20 : 9) && n <= ((i < 2) ? 22 : 11), 1'b1);
    end
    // Minute unit
    ipwt_host_model_inst.regWr(IPWT_IDX_UNIT_CFG, 8'h08);
    ipwt_host_model_inst.regRd(IPWT_IDX_UNIT_CFG, rdv);
    check(rdv, 8'h08);
    ipwt_host_model_inst.regWr(IPWT_IDX_COUNT, 8'h01);
    waitPulse(700, n);
    check(n >= 60 * SC + 1 && n <= 60 * SC + 3, 1'b1);
    // Forced timeout, bit reads back clear
    ipwt_host_model_inst.regWr(IPWT_IDX_COUNT, 8'h00);
    ipwt_host_model_inst.regWr(IPWT_IDX_CTRL_STAT, 8'h20);
    waitPulse(5, n);
    check(n, 1);
    ipwt_host_model_inst.regRd(IPWT_IDX_CTRL_STAT, rdv);
    check(rdv & 8'h30, 8'h10);
    // Disable clears status and silences the timer
    ipwt_host_model_inst.regWr(IPWT_IDX_FUNC_ENABLE, 8'h00);
    check(timeoutStatus, 1'b0);
    ipwt_host_model_inst.regWr(IPWT_IDX_COUNT, 8'h01);
    ipwt_host_model_inst.regWr(IPWT_IDX_CTRL_STAT, 8'h20);
    waitPulse(40, n);
    check(n, 41);
    ipwt_host_model_inst.lock();
    ipwt_host_model_inst.regRd(IPWT_IDX_DEV_SELECT, rdv);
    check(rdv, 8'hFF);
    ipwt_host_model_inst.unlock();
    ipwt_host_model_inst.regRd(IPWT_IDX_DEV_SELECT, rdv);
    check(rdv, 8'h08);
    end_of_test();
  end
endmodule
